// ---- src/ads_pkg.sv ----
// Package: register map, field positions, reset values and timing counts for the status block
package ads_pkg;
    // Register byte addresses on the core bus
    localparam logic [31:0] ADDR_STATUS    = 32'hFFFF0500;
    localparam logic [31:0] ADDR_MASK      = 32'hFFFF0504;
    localparam logic [31:0] ADDR_MODE      = 32'hFFFF0508;
    localparam logic [31:0] ADDR_CONFIG    = 32'hFFFF050C;
    localparam logic [31:0] ADDR_CUR_RES   = 32'hFFFF0510;
    localparam logic [31:0] ADDR_VOLT_RES  = 32'hFFFF0514;
    localparam logic [31:0] ADDR_TEMP_RES  = 32'hFFFF0518;
    localparam logic [31:0] ADDR_THRESHOLD = 32'hFFFF051C;
    localparam logic [31:0] ADDR_CNT_LIMIT = 32'hFFFF0520;
    localparam logic [31:0] ADDR_GAIN      = 32'hFFFF0524;
    // Status bit positions
    localparam int ST_CAL    = 15;
    localparam int ST_TERR   = 14;
    localparam int ST_VERR   = 13;
    localparam int ST_CERR   = 12;
    localparam int ST_THR    = 4;
    localparam int ST_FOVR   = 3;
    localparam int ST_TRDY   = 2;
    localparam int ST_VRDY   = 1;
    localparam int ST_CRDY   = 0;
    // Configuration bit positions
    localparam int CFG_CMP_EN  = 0;
    localparam int CFG_CNT_EN  = 1;
    localparam int CFG_OVR_EN  = 2;
    localparam int CFG_CUR_EN  = 3;
    localparam int CFG_VOLT_EN = 4;
    localparam int CFG_TEMP_EN = 5;
    // Reset values
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [7:0]  MASK_RST   = 8'h00;
    localparam logic [7:0]  MODE_RST   = 8'h00;
    localparam logic [7:0]  CONFIG_RST = 8'h00;
    localparam logic [15:0] RES_RST    = 16'h0000;
    localparam logic [15:0] THR_RST    = 16'h0000;
    localparam logic [7:0]  LIMIT_RST  = 8'h00;
    localparam logic [3:0]  GAIN_RST   = 4'h0;
    // Clamp codes for out-of-range conversions
    localparam logic [15:0] POS_FULL_SCALE = 16'h7FFF;
    localparam logic [15:0] NEG_FULL_SCALE = 16'h8000;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Fast overrange evaluation period
    localparam int CLK_FREQ_MHZ   = 200;
    localparam int FOVR_PERIOD_US = 125;
    localparam int FOVR_CYCLES    = FOVR_PERIOD_US * CLK_FREQ_MHZ;
endpackage : ads_pkg

// ---- src/ads_status.sv ----
// Converter status flags with AXI4-Lite register access
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
module ads_status
    import ads_pkg::*;
#(
    parameter int FOVR_PERIOD = FOVR_CYCLES
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write channels
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Converter datapath events
    input  wire logic        cal_done,
    input  wire logic        cur_valid,
    input  wire logic [15:0] cur_data,
    input  wire logic        cur_over,
    input  wire logic        cur_under,
    input  wire logic        volt_valid,
    input  wire logic [15:0] volt_data,
    input  wire logic        volt_over,
    input  wire logic        volt_under,
    input  wire logic        temp_valid,
    input  wire logic [15:0] temp_data,
    input  wire logic        temp_over,
    input  wire logic        temp_under,
    input  wire logic        core_powered_down,
    // Analog gross overrange comparator, asynchronous
    input  wire logic        fast_ovr_in,
    // Interrupt request
    output logic             adc_irq
);
    // Register state
    logic [7:0]  mask_r, mode_r, cfg_r, limit_r;
    logic [15:0] thresh_r;
    logic [3:0]  gain_r;
    logic [15:0] cur_res_r, volt_res_r, temp_res_r;
    // Status flags
    logic        cal_r, terr_r, verr_r, cerr_r, thr_r, fovr_r;
    logic [2:0]  rdy_r;
    logic [7:0]  thr_cnt_r;
    // Fast overrange synchroniser and tick
    logic        ovr_meta_r, ovr_sync_r, tick;
    logic [31:0] tick_cnt_r;
    // Bus control
    logic        awready_r, bvalid_r, arready_r, rvalid_r, irq_r;
    logic [1:0]  bresp_r, rresp_r;
    logic [31:0] rdata_r;
    // Decoded strobes
    logic        wr_fire, rd_fire, wr_mode, wr_gain, rd_cur, rd_volt, rd_temp;
    logic        cur_take, volt_take, temp_take, cur_bad, volt_bad, temp_bad;
    logic        cur_exceed;
    logic [15:0] cur_mag, stat_word;
    logic [7:0]  wbyte0;

    // Clamp an errored conversion to the matching full-scale code
    function automatic logic [15:0] clamp(input logic [15:0] d, input logic ov,
                                          input logic un);
        return ov ? POS_FULL_SCALE : (un ? NEG_FULL_SCALE : d);
    endfunction : clamp

    // Strobes; write fires on the cycle both address and data are taken
    assign wr_fire   = s_axi_awvalid && awready_r;
    assign rd_fire   = s_axi_arvalid && arready_r;
    assign wr_mode   = wr_fire && (s_axi_awaddr == ADDR_MODE);
    assign wr_gain   = wr_fire && (s_axi_awaddr == ADDR_GAIN) && s_axi_wstrb[0];
    assign rd_cur    = rd_fire && (s_axi_araddr == ADDR_CUR_RES);
    assign rd_volt   = rd_fire && (s_axi_araddr == ADDR_VOLT_RES);
    assign rd_temp   = rd_fire && (s_axi_araddr == ADDR_TEMP_RES);
    assign wbyte0    = s_axi_wdata[7:0];
    // A full result register blocks overwrite while the core runs
    assign cur_take  = cur_valid && (!rdy_r[ST_CRDY] || core_powered_down);
    assign volt_take = volt_valid && (!rdy_r[ST_VRDY] || core_powered_down);
    assign temp_take = temp_valid && (!rdy_r[ST_TRDY] || core_powered_down);
    assign cur_bad   = cur_over || cur_under;
    assign volt_bad  = volt_over || volt_under;
    assign temp_bad  = temp_over || temp_under;
    // Magnitude of a signed result; 0x8000 saturates to 0x7FFF so it still compares above any threshold below 0x7FFF
    assign cur_mag    = cur_data[15] ? ((cur_data == NEG_FULL_SCALE) ? POS_FULL_SCALE
                                                                     : 16'(-cur_data))
                                     : cur_data;
    assign cur_exceed = cur_valid && cfg_r[CFG_CMP_EN] && (cur_mag > thresh_r);
    assign tick       = (tick_cnt_r == 32'(FOVR_PERIOD - 1));
    // Reserved bits are tied low
    assign stat_word  = {cal_r, terr_r, verr_r, cerr_r, 7'h00, thr_r, fovr_r, rdy_r};

    // Write address/data acceptance: both taken together, one write in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
        end else begin
            awready_r <= s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;
        end
    end

    // Write response; writes to read-only status are accepted but ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            unique case (s_axi_awaddr)
                ADDR_STATUS, ADDR_MASK, ADDR_MODE, ADDR_CONFIG, ADDR_CUR_RES,
                ADDR_VOLT_RES, ADDR_TEMP_RES, ADDR_THRESHOLD, ADDR_CNT_LIMIT,
                ADDR_GAIN: bresp_r <= RESP_OKAY;
                default:   bresp_r <= RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Writable control registers, low byte lanes honoured
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_r   <= MASK_RST;
            mode_r   <= MODE_RST;
            cfg_r    <= CONFIG_RST;
            thresh_r <= THR_RST;
            limit_r  <= LIMIT_RST;
            gain_r   <= GAIN_RST;
        end else if (wr_fire) begin
            if (s_axi_wstrb[0]) begin
                unique case (s_axi_awaddr)
                    ADDR_MASK:      mask_r        <= wbyte0;
                    ADDR_MODE:      mode_r        <= wbyte0;
                    ADDR_CONFIG:    cfg_r         <= wbyte0;
                    ADDR_THRESHOLD: thresh_r[7:0] <= wbyte0;
                    ADDR_CNT_LIMIT: limit_r       <= wbyte0;
                    ADDR_GAIN:      gain_r        <= wbyte0[3:0];
                    default:        ;
                endcase
            end
            if (s_axi_wstrb[1] && s_axi_awaddr == ADDR_THRESHOLD) begin
                thresh_r[15:8] <= s_axi_wdata[15:8];
            end
        end
    end

    // Read acceptance, one read in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
        end else begin
            arready_r <= s_axi_arvalid && !arready_r && !rvalid_r;
        end
    end

    // Read data; narrow registers sit in the low bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h00000000;
            rresp_r  <= RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_r <= 1'b1;
            rresp_r  <= RESP_OKAY;
            unique case (s_axi_araddr)
                ADDR_STATUS:    rdata_r <= {16'h0000, stat_word};
                ADDR_MASK:      rdata_r <= {24'h000000, mask_r};
                ADDR_MODE:      rdata_r <= {24'h000000, mode_r};
                ADDR_CONFIG:    rdata_r <= {24'h000000, cfg_r};
                ADDR_CUR_RES:   rdata_r <= {16'h0000, cur_res_r};
                ADDR_VOLT_RES:  rdata_r <= {16'h0000, volt_res_r};
                ADDR_TEMP_RES:  rdata_r <= {16'h0000, temp_res_r};
                ADDR_THRESHOLD: rdata_r <= {16'h0000, thresh_r};
                ADDR_CNT_LIMIT: rdata_r <= {24'h000000, limit_r};
                ADDR_GAIN:      rdata_r <= {28'h0000000, gain_r};
                default: begin
                    rdata_r <= 32'h00000000;
                    rresp_r <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Result registers, clamped on error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur_res_r  <= RES_RST;
            volt_res_r <= RES_RST;
            temp_res_r <= RES_RST;
        end else begin
            if (cur_take) begin
                cur_res_r <= clamp(cur_data, cur_over, cur_under);
            end
            if (volt_take) begin
                volt_res_r <= clamp(volt_data, volt_over, volt_under);
            end
            if (temp_take) begin
                temp_res_r <= clamp(temp_data, temp_over, temp_under);
            end
        end
    end

    // Calibration flag; a completion in the same cycle as a mode write wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cal_r <= STATUS_RST[ST_CAL];
        end else if (cal_done) begin
            cal_r <= 1'b1;
        end else if (wr_mode) begin
            cal_r <= 1'b0;
        end
    end

    // Conversion error flags; an error is flagged even if the result is blocked
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            terr_r <= STATUS_RST[ST_TERR];
            verr_r <= STATUS_RST[ST_VERR];
            cerr_r <= STATUS_RST[ST_CERR];
        end else begin
            if (temp_valid && temp_bad) begin
                terr_r <= 1'b1;
            end else if (temp_take) begin
                terr_r <= 1'b0;
            end
            if (volt_valid && volt_bad) begin
                verr_r <= 1'b1;
            end else if (volt_take) begin
                verr_r <= 1'b0;
            end
            if (cur_valid && cur_bad) begin
                cerr_r <= 1'b1;
            end else if (cur_take) begin
                cerr_r <= 1'b0;
            end
        end
    end

    // Threshold flag with optional conversion counter; cleared by a current result read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            thr_r     <= STATUS_RST[ST_THR];
            thr_cnt_r <= 8'h00;
        end else begin
            if (cur_exceed && !cfg_r[CFG_CNT_EN]) begin
                thr_r <= 1'b1;
            end else if (cur_exceed && (thr_cnt_r + 8'h01 >= limit_r)) begin
                thr_r     <= 1'b1;
                thr_cnt_r <= 8'h00;
            end else begin
                if (cur_exceed) begin
                    thr_cnt_r <= thr_cnt_r + 8'h01;
                end
                if (rd_cur) begin
                    thr_r <= 1'b0;
                end
            end
        end
    end

    // Two-flop synchroniser for the analog overrange comparator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovr_meta_r <= 1'b0;
            ovr_sync_r <= 1'b0;
        end else begin
            ovr_meta_r <= fast_ovr_in;
            ovr_sync_r <= ovr_meta_r;
        end
    end

    // Evaluation period counter, free running
    always_ff @(posedge aclk) begin
        if (!aresetn || tick) begin
            tick_cnt_r <= 32'h00000000;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h00000001;
        end
    end

    // Fast overrange: sampled once per period, sticky until disable or gain change
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fovr_r <= STATUS_RST[ST_FOVR];
        end else if (tick && cfg_r[CFG_OVR_EN] && ovr_sync_r) begin
            fovr_r <= 1'b1;
        end else if (!cfg_r[CFG_OVR_EN] || (wr_gain && wbyte0[3:0] != gain_r)) begin
            fovr_r <= 1'b0;
        end
    end

    // Result-ready flags; sets beat clearing reads of the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdy_r <= STATUS_RST[2:0];
        end else begin
            // Current ready
            if (cal_done || (cur_take && cfg_r[CFG_CUR_EN])) begin
                rdy_r[ST_CRDY] <= 1'b1;
            end else if (rd_cur || ((rd_volt || rd_temp) && !cfg_r[CFG_CUR_EN])) begin
                rdy_r[ST_CRDY] <= 1'b0;
            end
            // Voltage ready
            if (cal_done || (volt_take && cfg_r[CFG_VOLT_EN])) begin
                rdy_r[ST_VRDY] <= 1'b1;
            end else if (rd_cur || rd_volt || (rd_temp && !cfg_r[CFG_CUR_EN])) begin
                rdy_r[ST_VRDY] <= 1'b0;
            end
            // Temperature ready
            if (cal_done || (temp_take && cfg_r[CFG_TEMP_EN])) begin
                rdy_r[ST_TRDY] <= 1'b1;
            end else if (rd_cur || rd_temp || (rd_volt && !cfg_r[CFG_CUR_EN])) begin
                rdy_r[ST_TRDY] <= 1'b0;
            end
        end
    end

    // Interrupt: masked low byte ORed; upper flags never interrupt
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(stat_word[7:0] & mask_r);
        end
    end

    // Outputs straight from flops
    assign s_axi_awready = awready_r;
    assign s_axi_wready  = awready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign adc_irq       = irq_r;

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_cal_set;
        cal_done |=> cal_r && (rdy_r == 3'b111);
    endproperty
    a_cal_set: assert property (p_cal_set) else $error("calibration flags not set");
    property p_mode_clr;
        wr_mode && !cal_done |=> !cal_r;
    endproperty
    a_mode_clr: assert property (p_mode_clr) else $error("mode write kept cal flag");
    property p_clamp;
        cur_take && cur_over |=> cur_res_r == POS_FULL_SCALE;
    endproperty
    a_clamp: assert property (p_clamp) else $error("overrange not clamped");
    property p_hold;
        rdy_r[ST_CRDY] && !core_powered_down |=> $stable(cur_res_r);
    endproperty
    a_hold: assert property (p_hold) else $error("result overwritten while ready");
    property p_irq;
        ##1 adc_irq == $past(|(stat_word[7:0] & mask_r));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not masked OR");
    property p_fovr_tick;
        $rose(fovr_r) |-> $past(tick) && $past(ovr_sync_r);
    endproperty
    a_fovr_tick: assert property (p_fovr_tick) else $error("overrange set off tick");
    property p_cur_err;
        cur_valid && cur_bad |=> cerr_r ##0 stat_word[ST_CERR];
    endproperty
    a_cur_err: assert property (p_cur_err) else $error("current error not flagged");
    property p_rd_cur;
        rd_cur && !cal_done && !cur_take && !volt_take && !temp_take |=> rdy_r == 3'b000;
    endproperty
    a_rd_cur: assert property (p_rd_cur) else $error("current read left ready set");
    // Upper half and the reserved field of a status read must both be zero
    property p_rsv;
        rvalid_r && $past(rd_fire && s_axi_araddr == ADDR_STATUS) |->
            rdata_r[31:16] == 16'h0000 && rdata_r[11:5] == 7'h00;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved status bits nonzero");
endmodule : ads_status

// ---- verification/tb_top.sv ----
// Self-checking bench for the converter status flag block
`timescale 1ns/100ps
module tb_top;
    import ads_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rdv;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic        cal = 1'b0, pd = 1'b0, fovr = 1'b0;
    logic [1:0]  bresp, rresp, rsp, bsp;
    logic [2:0]  vld = 3'h0, ov = 3'h0, un = 3'h0;
    logic [15:0] dat [3] = '{16'h0000, 16'h0000, 16'h0000};
    int          n_mismatch = 0;
    int          check_count = 0;

    // Short overrange period keeps the run brief
    ads_status #(.FOVR_PERIOD(8)) uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cal_done(cal),
        .cur_valid(vld[0]), .cur_data(dat[0]), .cur_over(ov[0]), .cur_under(un[0]),
        .volt_valid(vld[1]), .volt_data(dat[1]), .volt_over(ov[1]), .volt_under(un[1]),
        .temp_valid(vld[2]), .temp_data(dat[2]), .temp_over(ov[2]), .temp_under(un[2]),
        .core_powered_down(pd), .fast_ovr_in(fovr), .adc_irq(irq));

    always #2.5 aclk = ~aclk;

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Address and data offered together, each released at its own handshake
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bit aw_done;
        bit w_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!(aw_done && w_done));
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready  <= 1'b0;
        bsp = bresp;
    endtask : wr

    task automatic rd(input logic [31:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready  <= 1'b0;
        rdv = rdata;
        rsp = rresp;
    endtask : rd

    task automatic rc(input logic [31:0] a, input logic [31:0] exp);
        rd(a);
        chk($sformatf("reg %h", a), rdv, exp);
    endtask : rc

    // One conversion pulse on channel 0 current, 1 voltage, 2 temperature
    task automatic cv(input int ch, input logic [15:0] d, input logic o, input logic u);
        @(posedge aclk);
        vld[ch] <= 1'b1;
        dat[ch] <= d;
        ov[ch]  <= o;
        un[ch]  <= u;
        @(posedge aclk);
        vld[ch] <= 1'b0;
        ov[ch]  <= 1'b0;
        un[ch]  <= 1'b0;
    endtask : cv

    task automatic pulse_cal;
        @(posedge aclk);
        cal <= 1'b1;
        @(posedge aclk);
        cal <= 1'b0;
    endtask : pulse_cal

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    // Watchdog sized well above the expected run of about three hundred cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rc(ADDR_STATUS, 32'h0000_0000);
        rc(ADDR_MASK, 32'h0000_0000);
        wr(ADDR_STATUS, 32'h0000_FFFF);
        chk("status write resp", {30'h0, bsp}, {30'h0, RESP_OKAY});
        rc(ADDR_STATUS, 32'h0000_0000);
        rc(32'hFFFF05FC, 32'h0000_0000);
        chk("unmapped resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
        // All three channels on, ready interrupts unmasked
        wr(ADDR_CONFIG, 32'h0000_0038);
        wr(ADDR_MASK, 32'h0000_0007);
        pulse_cal();
        rc(ADDR_STATUS, 32'h0000_8007);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(ADDR_MODE, 32'h0000_0000);
        rc(ADDR_STATUS, 32'h0000_0007);
        rd(ADDR_VOLT_RES);
        rc(ADDR_STATUS, 32'h0000_0005);
        rd(ADDR_TEMP_RES);
        rc(ADDR_STATUS, 32'h0000_0001);
        rd(ADDR_CUR_RES);
        rc(ADDR_STATUS, 32'h0000_0000);
        chk("irq", {31'h0, irq}, 32'h0);
        cv(1, 16'h1234, 1'b1, 1'b0);
        rc(ADDR_STATUS, 32'h0000_2002);
        rc(ADDR_VOLT_RES, 32'h0000_7FFF);
        rc(ADDR_STATUS, 32'h0000_2000);
        chk("irq", {31'h0, irq}, 32'h0);
        cv(1, 16'h1234, 1'b0, 1'b0);
        rc(ADDR_STATUS, 32'h0000_0002);
        // Second result must not replace one still flagged ready
        cv(1, 16'h0777, 1'b0, 1'b0);
        rc(ADDR_VOLT_RES, 32'h0000_1234);
        pd <= 1'b1;
        cv(1, 16'h0AAA, 1'b0, 1'b0);
        cv(1, 16'h0BBB, 1'b0, 1'b0);
        pd <= 1'b0;
        rc(ADDR_VOLT_RES, 32'h0000_0BBB);
        cv(2, 16'h0055, 1'b0, 1'b1);
        rc(ADDR_STATUS, 32'h0000_4004);
        rc(ADDR_TEMP_RES, 32'h0000_8000);
        cv(2, 16'h0055, 1'b0, 1'b0);
        rc(ADDR_STATUS, 32'h0000_0004);
        rd(ADDR_CUR_RES);
        rc(ADDR_STATUS, 32'h0000_0000);
        cv(0, 16'h0123, 1'b1, 1'b0);
        rc(ADDR_STATUS, 32'h0000_1001);
        rc(ADDR_CUR_RES, 32'h0000_7FFF);
        cv(0, 16'h0123, 1'b0, 1'b0);
        rc(ADDR_STATUS, 32'h0000_0001);
        rd(ADDR_CUR_RES);
        // Negative result checked by magnitude against the threshold
        wr(ADDR_THRESHOLD, 32'h0000_0100);
        wr(ADDR_CONFIG, 32'h0000_0039);
        cv(0, 16'hFE00, 1'b0, 1'b0);
        rc(ADDR_STATUS, 32'h0000_0011);
        rc(ADDR_CUR_RES, 32'h0000_FE00);
        wr(ADDR_CNT_LIMIT, 32'h0000_0002);
        wr(ADDR_CONFIG, 32'h0000_003B);
        cv(0, 16'h0200, 1'b0, 1'b0);
        rc(ADDR_STATUS, 32'h0000_0001);
        rd(ADDR_CUR_RES);
        cv(0, 16'h0200, 1'b0, 1'b0);
        rc(ADDR_STATUS, 32'h0000_0011);
        rd(ADDR_CUR_RES);
        // Current channel off: one voltage read clears every ready flag
        wr(ADDR_CONFIG, 32'h0000_0030);
        pulse_cal();
        rd(ADDR_VOLT_RES);
        rc(ADDR_STATUS, 32'h0000_8000);
        wr(ADDR_MODE, 32'h0000_0000);
        wr(ADDR_CONFIG, 32'h0000_0004);
        fovr <= 1'b1;
        repeat (40) @(posedge aclk);
        rc(ADDR_STATUS, 32'h0000_0008);
        chk("irq", {31'h0, irq}, 32'h0);
        fovr <= 1'b0;
        repeat (40) @(posedge aclk);
        rc(ADDR_STATUS, 32'h0000_0008);
        wr(ADDR_GAIN, 32'h0000_0001);
        rc(ADDR_STATUS, 32'h0000_0000);
        wrap_up();
    end
endmodule : tb_top
